// ### design/uart_baud_pkg.sv
// uart_baud_pkg: register map, field positions, reset values and timing constants
// of the baud generator and line-format block.
// assumes: an APB slave with 32-bit data, one register per aligned word.
package uart_baud_pkg;

  // register indexes; byte address is four times the index
  localparam logic [2:0] IDX_DIV_HIGH = 3'h0;
  localparam logic [2:0] IDX_DIV_LOW = 3'h1;
  localparam logic [2:0] IDX_LINE_FMT = 3'h2;
  localparam logic [2:0] IDX_CTRL_TWO = 3'h3;
  localparam logic [2:0] IDX_STAT_TWO = 3'h5;
  localparam int ADDR_LSB = 2;

  // baud_divisor_high fields
  localparam int BDH_IR_EN = 7;
  localparam int BDH_PW_HI = 6;
  localparam int BDH_PW_LO = 5;
  // line_format_control fields
  localparam int LF_LOOP = 7;
  localparam int LF_STOP_WAIT = 6;
  localparam int LF_RX_SRC = 5;
  localparam int LF_NINE = 4;
  localparam int LF_WAKE = 3;
  localparam int LF_IDLE_START = 2;
  localparam int LF_PAR_EN = 1;
  localparam int LF_PAR_TYPE = 0;
  // control register two fields
  localparam int C2_TX_EN = 3;
  localparam int C2_RX_EN = 2;
  // status register two fields
  localparam int S2_ALT_MAP = 7;
  localparam int S2_TX_POL = 4;
  localparam int S2_RX_POL = 3;

  // writable masks
  localparam logic [7:0] S2_WMASK = 8'h9E;
  localparam logic [7:0] ALT_CTL1_MASK = 8'h83;
  localparam logic [7:0] ALT_CTL2_MASK = 8'h07;

  // reset values
  localparam logic [7:0] RST_DIV_HIGH = 8'h00;
  localparam logic [7:0] RST_DIV_LOW = 8'h04;
  localparam logic [7:0] RST_LINE_FMT = 8'h00;
  localparam logic [7:0] RST_CTRL_TWO = 8'h00;
  localparam logic [7:0] RST_STAT_TWO = 8'h00;

  // timing: sample ticks per bit, infrared sub-ticks per bit
  localparam int OVERSAMPLE = 16;
  localparam int DIV_W = 13;
  localparam int PHASE_W = 5;

  // narrow pulse widths in 1/32 of a bit, by pulse-width code
  localparam logic [PHASE_W-1:0] PW_QUARTER = 5'h08;
  localparam logic [PHASE_W-1:0] PW_1_32 = 5'h01;
  localparam logic [PHASE_W-1:0] PW_1_16 = 5'h02;
  localparam logic [PHASE_W-1:0] PW_3_16 = 5'h06;

endpackage

// ### design/baud_if.sv
// baud_if: carries divisor settings to the baud generator and its ticks back.
// assumes: one clock domain shared by both ends.
`timescale 1ns/1ps
interface baud_if import uart_baud_pkg::*; ();
  logic [DIV_W-1:0] divisor;
  logic irEnable;
  logic startReq;
  logic active;
  logic running;
  logic tick16;
  logic tick32;
  logic bitTick;
  logic [PHASE_W-1:0] phase;

  modport gen (input divisor, irEnable, startReq, active,
               output running, tick16, tick32, bitTick, phase);
  modport user (output divisor, irEnable, startReq, active,
                input running, tick16, tick32, bitTick, phase);
endinterface

// ### design/baud_gen.sv
// baud_gen: divides the bus clock into sample ticks, infrared sub-ticks and bit ticks.
// assumes: divisor and mode come from the register file over baud_if.
`timescale 1ns/1ps
module baud_gen
  import uart_baud_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  baud_if.gen bif
);

  logic started_ff;
  logic [DIV_W-1:0] cnt_ff;
  logic half_ff;
  logic [3:0] ph16_ff;
  logic tick16_ff;
  logic tick32_ff;
  logic bitTick_ff;
  logic [DIV_W-1:0] effDiv;
  logic stopped;
  logic run;
  logic unitWrap;
  logic [DIV_W-1:0] nxt_cnt;

  //////////////////////////////////////////////////////////////////////////////
  // in infrared the unit is a 1/32 bit, so bit 0 of the divisor is dropped
  assign effDiv = bif.irEnable ? {1'b0, bif.divisor[DIV_W-1:1]} : bif.divisor;
  assign stopped = (effDiv == '0);
  assign run = started_ff && !stopped && bif.active;
  assign nxt_cnt = cnt_ff + 13'h0001;
  assign unitWrap = run && (nxt_cnt >= effDiv);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      started_ff <= 1'b0;
    end else if (bif.startReq) begin
      started_ff <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= '0;
    end else if (!run || unitWrap) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // sample tick at sixteen times the bit rate; two units per tick in infrared
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      half_ff <= 1'b0;
      ph16_ff <= 4'h0;
    end else if (!run) begin
      half_ff <= 1'b0;
      ph16_ff <= 4'h0;
    end else if (unitWrap) begin
      half_ff <= bif.irEnable ? !half_ff : 1'b0;
      if (!bif.irEnable || half_ff) begin
        ph16_ff <= ph16_ff + 4'h1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tick16_ff <= 1'b0;
      tick32_ff <= 1'b0;
      bitTick_ff <= 1'b0;
    end else begin
      tick32_ff <= unitWrap;
      tick16_ff <= unitWrap && (!bif.irEnable || half_ff);
      bitTick_ff <= unitWrap && (!bif.irEnable || half_ff) && (ph16_ff == 4'(OVERSAMPLE - 1));
    end
  end

  assign bif.running = run;
  assign bif.tick16 = tick16_ff;
  assign bif.tick32 = tick32_ff;
  assign bif.bitTick = bitTick_ff;
  assign bif.phase = {ph16_ff, half_ff};

endmodule

// ### design/uart_baud_format.sv
// uart_baud_format: APB register file, baud generator and line routing of the serial port.
// assumes: the character shifters sit outside and use the ticks and format outputs;
// the txd pin is resolved from txdOut/txdOe by the surroundings.
//
// The APB register port was chosen for this implementation.
`timescale 1ns/1ps

module uart_baud_format
  import uart_baud_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic waitMode,
  input wire logic txSerial,
  output logic rxSerial,
  input wire logic txdIn,
  output logic txdOut,
  output logic txdOe,
  input wire logic rxdIn,
  output logic sampleTick,
  output logic bitTick,
  output logic baudRunning,
  output logic txEnable,
  output logic rxEnable,
  output logic sciActive,
  output logic nineBitChar,
  output logic wakeAddrMark,
  output logic idleAfterStop,
  output logic parityEnable,
  output logic parityOdd,
  input wire logic [8:0] txChar,
  output logic txParityBit,
  input wire logic [8:0] rxChar,
  input wire logic rxCharValid,
  output logic rxParityError,
  output logic rxAddrMark
);

  logic [7:0] divHigh_ff;
  logic [7:0] divHighHold_ff;
  logic [7:0] divLow_ff;
  logic [7:0] lineFmt_ff;
  logic [7:0] ctrlTwo_ff;
  logic [7:0] statTwo_ff;
  logic [7:0] altCtl1_ff;
  logic [7:0] altCtl2_ff;
  logic [31:0] prdata_ff;
  logic slvErr_ff;
  logic [2:0] regIdx;
  logic addrOk;
  logic altMap;
  logic wrEn;
  logic [7:0] wByte;
  logic [7:0] nxt_rdByte;
  logic nxt_known;
  logic irOn;
  logic [PHASE_W-1:0] pulseWidth;
  logic txMod;
  logic txPin;
  logic rxSrc;
  logic rxDemod;
  logic irLowSeen_ff;
  logic txParityBit_ff;
  logic rxParityError_ff;
  logic rxAddrMark_ff;

  baud_if bif ();

  baud_gen u_baud_gen (
    .clk(clk),
    .rst_n(rst_n),
    .bif(bif)
  );

  //////////////////////////////////////////////////////////////////////////////
  // apb decode; read data is captured in the setup cycle, answer in first access cycle
  assign regIdx = paddr[ADDR_LSB+2:ADDR_LSB];
  assign addrOk = (paddr[ADDR_LSB-1:0] == '0) && (paddr[ADDR_W-1:ADDR_LSB+3] == '0);
  assign altMap = statTwo_ff[S2_ALT_MAP];
  assign wByte = pwdata[7:0];
  assign wrEn = psel && penable && pwrite && !slvErr_ff;
  assign pready = 1'b1;
  assign prdata = prdata_ff;
  assign pslverr = psel && penable && slvErr_ff;

  always_comb begin
    nxt_rdByte = 8'h00;
    nxt_known = addrOk;
    unique case (regIdx)
      IDX_DIV_HIGH: nxt_rdByte = altMap ? 8'h00 : divHigh_ff;
      IDX_DIV_LOW: nxt_rdByte = altMap ? altCtl1_ff : divLow_ff;
      IDX_LINE_FMT: nxt_rdByte = altMap ? altCtl2_ff : lineFmt_ff;
      IDX_CTRL_TWO: nxt_rdByte = ctrlTwo_ff;
      IDX_STAT_TWO: nxt_rdByte = statTwo_ff;
      default: nxt_known = 1'b0;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata_ff <= 32'h0000_0000;
      slvErr_ff <= 1'b0;
    end else if (psel && !penable) begin
      prdata_ff <= {24'h00_0000, nxt_known ? nxt_rdByte : 8'h00};
      slvErr_ff <= !nxt_known;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // divisor registers: the high byte waits in a holding latch
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      divHighHold_ff <= RST_DIV_HIGH;
      divHigh_ff <= RST_DIV_HIGH;
      divLow_ff <= RST_DIV_LOW;
    end else if (wrEn && !altMap) begin
      if (regIdx == IDX_DIV_HIGH) begin
        divHighHold_ff <= wByte;
      end
      if (regIdx == IDX_DIV_LOW) begin
        divLow_ff <= wByte;
        divHigh_ff <= divHighHold_ff;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lineFmt_ff <= RST_LINE_FMT;
    end else if (wrEn && !altMap && regIdx == IDX_LINE_FMT) begin
      lineFmt_ff <= wByte;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      altCtl1_ff <= 8'h00;
      altCtl2_ff <= 8'h00;
    end else if (wrEn && altMap) begin
      if (regIdx == IDX_DIV_LOW) begin
        altCtl1_ff <= wByte & ALT_CTL1_MASK;
      end
      if (regIdx == IDX_LINE_FMT) begin
        altCtl2_ff <= wByte & ALT_CTL2_MASK;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrlTwo_ff <= RST_CTRL_TWO;
    end else if (wrEn && regIdx == IDX_CTRL_TWO) begin
      ctrlTwo_ff <= wByte;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      statTwo_ff <= RST_STAT_TWO;
    end else if (wrEn && regIdx == IDX_STAT_TWO) begin
      statTwo_ff <= wByte & S2_WMASK;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // baud generator hookup
  assign txEnable = ctrlTwo_ff[C2_TX_EN];
  assign rxEnable = ctrlTwo_ff[C2_RX_EN];
  assign sciActive = !(waitMode && lineFmt_ff[LF_STOP_WAIT]);
  assign irOn = divHigh_ff[BDH_IR_EN];

  assign bif.divisor = {divHigh_ff[4:0], divLow_ff};
  assign bif.irEnable = irOn;
  assign bif.startReq = txEnable || rxEnable;
  assign bif.active = sciActive;

  assign sampleTick = bif.tick16;
  assign bitTick = bif.bitTick;
  assign baudRunning = bif.running;

  //////////////////////////////////////////////////////////////////////////////
  // transmit path: a zero bit becomes a narrow low pulse at the bit start in infrared
  always_comb begin
    unique case (divHigh_ff[BDH_PW_HI:BDH_PW_LO])
      2'b11: pulseWidth = PW_QUARTER;
      2'b10: pulseWidth = PW_1_32;
      2'b01: pulseWidth = PW_1_16;
      2'b00: pulseWidth = PW_3_16;
    endcase
  end

  assign txMod = irOn ? !(!txSerial && bif.running && (bif.phase < pulseWidth)) : txSerial;
  assign txPin = txMod ^ statTwo_ff[S2_TX_POL];
  assign txdOut = txEnable ? txPin : 1'b1;
  assign txdOe = txEnable && sciActive;

  //////////////////////////////////////////////////////////////////////////////
  // receive path: loop and single-wire routing, then infrared stretch
  always_comb begin
    if (lineFmt_ff[LF_LOOP]) begin
      rxSrc = lineFmt_ff[LF_RX_SRC] ? txdIn : txPin;
    end else begin
      rxSrc = rxdIn;
    end
  end

  // a low pulse seen in a bit holds the line low until the next bit boundary
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irLowSeen_ff <= 1'b0;
    end else if (!irOn) begin
      irLowSeen_ff <= 1'b0;
    end else if (!(rxSrc ^ statTwo_ff[S2_RX_POL])) begin
      irLowSeen_ff <= 1'b1;
    end else if (bif.bitTick) begin
      irLowSeen_ff <= 1'b0;
    end
  end

  assign rxDemod = irOn ? !(irLowSeen_ff || !(rxSrc ^ statTwo_ff[S2_RX_POL]))
                        : (rxSrc ^ statTwo_ff[S2_RX_POL]);
  assign rxSerial = (rxEnable && sciActive) ? rxDemod : 1'b1;

  //////////////////////////////////////////////////////////////////////////////
  // line format for the shifters
  assign nineBitChar = lineFmt_ff[LF_NINE];
  assign wakeAddrMark = lineFmt_ff[LF_WAKE];
  assign idleAfterStop = lineFmt_ff[LF_IDLE_START];
  assign parityEnable = lineFmt_ff[LF_PAR_EN];
  assign parityOdd = lineFmt_ff[LF_PAR_TYPE];

  function automatic logic calc_parity(input logic [8:0] ch, input logic nine, input logic odd);
    logic ones;
    ones = nine ? ^ch[7:0] : ^ch[6:0];
    calc_parity = ones ^ odd;
  endfunction

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      txParityBit_ff <= 1'b0;
    end else begin
      txParityBit_ff <= calc_parity(txChar, nineBitChar, parityOdd);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rxParityError_ff <= 1'b0;
      rxAddrMark_ff <= 1'b0;
    end else if (rxCharValid) begin
      rxParityError_ff <= parityEnable &&
        (calc_parity(rxChar, nineBitChar, parityOdd) != (nineBitChar ? rxChar[8] : rxChar[7]));
      rxAddrMark_ff <= wakeAddrMark && (nineBitChar ? rxChar[8] : rxChar[7]);
    end
  end

  assign txParityBit = txParityBit_ff;
  assign rxParityError = rxParityError_ff;
  assign rxAddrMark = rxAddrMark_ff;

endmodule

// ### testbench/uart_baud_properties.sv
// uart_baud_checker: port-level properties of the baud and line-format block
// assumes: bound into uart_baud_format, one clock domain
`timescale 1ns/1ps
module uart_baud_checker
  import uart_baud_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input wire logic clk, rst_n, psel, penable,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready, pslverr, sciActive, txEnable, rxEnable, txdOut, txdOe,
  input wire logic sampleTick, bitTick, baudRunning, nineBitChar, wakeAddrMark, parityEnable, parityOdd,
  input wire logic [8:0] txChar, rxChar,
  input wire logic rxCharValid, txParityBit, rxParityError, rxAddrMark
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic everEn_ff;
  logic [4:0] tickCnt_ff;
  logic expTxPar, expRxErr, expMark;
  assign expTxPar = ^(nineBitChar ? txChar[7:0] : {1'b0, txChar[6:0]}) ^ parityOdd;
  assign expRxErr = ^(nineBitChar ? rxChar : {1'b0, rxChar[7:0]}) ^ parityOdd;
  assign expMark = wakeAddrMark && (nineBitChar ? rxChar[8] : rxChar[7]);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) everEn_ff <= 1'b0;
    else if (txEnable || rxEnable) everEn_ff <= 1'b1;
  end
  // sample ticks seen since the last bit tick
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) tickCnt_ff <= 5'h00;
    else if (!baudRunning || bitTick) tickCnt_ff <= 5'h00;
    else if (sampleTick) tickCnt_ff <= tickCnt_ff + 5'h01;
  end
  //////////////////////////////////////////////////////////////////////////////
  sequence s_access;
    psel && penable;
  endsequence
  sequence s_bad_addr;
    paddr[1:0] != 2'h0 || paddr[4:2] == 3'h4 || paddr[4:2] > 3'h5 || paddr[ADDR_W-1:5] != '0;
  endsequence
  property p_bad; s_access ##0 s_bad_addr |-> pslverr && prdata == 32'h0; endproperty
  a_bad: assert property (p_bad) else $error("bad address not refused");
  property p_oe; txdOe == (txEnable && sciActive); endproperty
  a_oe: assert property (p_oe) else $error("pin enable wrong");
  property p_idle; !txEnable |-> txdOut; endproperty
  a_idle: assert property (p_idle) else $error("pin not idle high");
  property p_start; !everEn_ff |-> !baudRunning; endproperty
  a_start: assert property (p_start) else $error("generator ran before enable");
  property p_stop; !baudRunning [*2] |-> !sampleTick; endproperty
  a_stop: assert property (p_stop) else $error("tick while stopped");
  property p_wait; !sciActive [*3] |-> !baudRunning && !sampleTick; endproperty
  a_wait: assert property (p_wait) else $error("generator runs in wait stop");
  property p_bit16; bitTick |-> sampleTick && tickCnt_ff == 5'h0F; endproperty
  a_bit16: assert property (p_bit16) else $error("bit tick not on 16th sample");
  property p_txpar; parityEnable |=> txParityBit == $past(expTxPar); endproperty
  a_txpar: assert property (p_txpar) else $error("tx parity wrong");
  property p_rxpar; rxCharValid && parityEnable |=> rxParityError == $past(expRxErr); endproperty
  a_rxpar: assert property (p_rxpar) else $error("rx parity error wrong");
  property p_mark; rxCharValid |=> rxAddrMark == $past(expMark); endproperty
  a_mark: assert property (p_mark) else $error("address mark wrong");
  property p_ready; s_access |-> pready; endproperty
  a_ready: assert property (p_ready) else $error("no ready in access");
endmodule

bind uart_baud_format uart_baud_checker #(.ADDR_W(ADDR_W)) u_uart_baud_checker (
  .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .sciActive(sciActive), .txEnable(txEnable), .rxEnable(rxEnable), .txdOut(txdOut),
  .txdOe(txdOe), .sampleTick(sampleTick), .bitTick(bitTick), .baudRunning(baudRunning),
  .nineBitChar(nineBitChar), .wakeAddrMark(wakeAddrMark), .parityEnable(parityEnable), .parityOdd(parityOdd),
  .txChar(txChar), .rxChar(rxChar), .rxCharValid(rxCharValid), .txParityBit(txParityBit),
  .rxParityError(rxParityError), .rxAddrMark(rxAddrMark));

// ### testbench/line_peer.sv
// line_peer: serial device on the far side of the pins
// assumes: txd line has a pull-up; rxd is driven only while the peer talks
`timescale 1ns/1ps
module line_peer (
  input wire logic txdOut,
  input wire logic txdOe,
  input wire logic talk,
  input wire logic talkBit,
  output logic txdPin,
  output logic rxdPin
);
  // a released transmit line floats up to the pull-up
  assign txdPin = txdOe ? txdOut : 1'b1;
  // a silent peer leaves the receive line idle high
  assign rxdPin = talk ? talkBit : 1'b1;
endmodule

// ### testbench/tb.sv
// tb: self-checking bench of uart_baud_format with random and corner cases
// assumes: APB master tasks, line_peer on the pins, checker bound separately
`timescale 1ns/1ps
module tb;
  import uart_baud_pkg::*;
  logic clk, rst_n, psel, penable, pwrite, waitMode, txSerial, talk, talkBit, rxCharValid;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdv, b;
  logic [8:0] txChar, rxChar;
  logic pready, pslverr, rxSerial, txdIn, txdOut, txdOe, rxdIn, sampleTick, bitTick, baudRunning;
  logic txEnable, rxEnable, sciActive, nineBitChar, wakeAddrMark, idleAfterStop, parityEnable, parityOdd;
  logic txParityBit, rxParityError, rxAddrMark, errv;
  int n_errors = 0;
  int checks_done = 0;
  int n, d, m;
  int pwTab[4] = '{6, 2, 1, 8};
  logic [31:0] seed = 32'h0000005E;
  uart_baud_format u_uart_baud_format (
    .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .waitMode(waitMode),
    .txSerial(txSerial), .rxSerial(rxSerial), .txdIn(txdIn), .txdOut(txdOut), .txdOe(txdOe),
    .rxdIn(rxdIn), .sampleTick(sampleTick), .bitTick(bitTick), .baudRunning(baudRunning),
    .txEnable(txEnable), .rxEnable(rxEnable), .sciActive(sciActive), .nineBitChar(nineBitChar),
    .wakeAddrMark(wakeAddrMark), .idleAfterStop(idleAfterStop), .parityEnable(parityEnable),
    .parityOdd(parityOdd), .txChar(txChar), .txParityBit(txParityBit), .rxChar(rxChar),
    .rxCharValid(rxCharValid), .rxParityError(rxParityError), .rxAddrMark(rxAddrMark));
  line_peer u_line_peer (.txdOut(txdOut), .txdOe(txdOe), .talk(talk), .talkBit(talkBit),
    .txdPin(txdIn), .rxdPin(rxdIn));
  //////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic tpar(input logic [31:0] v);
    return ^(v[4] ? v[15:8] : {1'b0, v[14:8]}) ^ v[0];
  endfunction
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] dv);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, dv};
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rdv = prdata;
    errv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [2:0] idx, input logic [7:0] dv);
    apb(1'b1, {3'h0, idx, 2'h0}, dv);
  endtask
  task automatic rdc(input string nm, input logic [2:0] idx, input logic [7:0] exp);
    apb(1'b0, {3'h0, idx, 2'h0}, 8'h00);
    chk(nm, rdv, {24'h000000, exp});
  endtask
  task automatic setdiv(input logic [12:0] dv, input logic ir, input logic [1:0] pw);
    wr(IDX_DIV_HIGH, {ir, pw, dv[12:8]});
    wr(IDX_DIV_LOW, dv[7:0]);
  endtask
  // cycles from one tick to the next; the first two ticks may still carry the old divisor
  task automatic period(input logic bt, output int p);
    p = 0;
    repeat (2) begin
      repeat (3000) begin
        @(posedge clk);
        if ((bt ? bitTick : sampleTick) === 1'b1) break;
      end
    end
    repeat (3000) begin
      @(posedge clk);
      p++;
      if ((bt ? bitTick : sampleTick) === 1'b1) break;
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    #300000;
    n_errors++;
    print_verdict();
  end
  initial begin
    {rst_n, psel, penable, pwrite, paddr, pwdata, waitMode, talk, rxCharValid} = '0;
    {txSerial, talkBit} = 2'h3;
    txChar = 9'h000;
    rxChar = 9'h000;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    rdc("div_high", IDX_DIV_HIGH, RST_DIV_HIGH);
    rdc("div_low", IDX_DIV_LOW, RST_DIV_LOW);
    rdc("line_fmt", IDX_LINE_FMT, RST_LINE_FMT);
    apb(1'b0, 8'h10, 8'h00);
    chk("unmapped_err", errv, 1);
    apb(1'b1, 8'h09, 8'hFF);
    chk("misaligned_err", errv, 1);
    repeat (50) @(posedge clk);
    chk("stopped_before_enable", baudRunning, 0);
    wr(IDX_DIV_HIGH, 8'h01);
    rdc("high_held", IDX_DIV_HIGH, 8'h00);
    wr(IDX_DIV_LOW, 8'h03);
    rdc("high_commit", IDX_DIV_HIGH, 8'h01);
    wr(IDX_CTRL_TWO, 8'h0C);
    repeat (3) @(posedge clk);
    chk("started", {baudRunning, txdOe, txdOut}, 3'h7);
    $display("test reset and map done");
    for (int i = 0; i < 6; i++) begin
      d = xs() % 9 + 2;
      setdiv(13'(d), i[0], 2'h0);
      d = i[0] ? 2 * (d / 2) : d;
      period(1'b0, n);
      chk("sample_period", n, d);
      period(1'b1, n);
      chk("bit_period", n, 16 * d);
    end
    setdiv(13'h0000, 1'b0, 2'h0);
    repeat (4) @(posedge clk);
    chk("zero_div", baudRunning, 0);
    setdiv(13'h0001, 1'b1, 2'h0);
    repeat (4) @(posedge clk);
    chk("zero_ir_div", baudRunning, 0);
    $display("test baud rates done");
    txSerial <= 1'b0;
    for (int c = 0; c < 4; c++) begin
      setdiv(13'h0004, 1'b1, c[1:0]);
      period(1'b1, n);
      n = 0;
      repeat (64) begin
        @(posedge clk);
        if (txdOut === 1'b0) n++;
      end
      chk("pulse_len", n, 2 * pwTab[c]);
    end
    setdiv(13'h0004, 1'b0, 2'h0);
    repeat (3) @(posedge clk);
    chk("nrz_out", txdOut, 0);
    txSerial <= 1'b1;
    $display("test infrared done");
    for (int i = 0; i < 12; i++) begin
      m = i % 3;
      wr(IDX_LINE_FMT, m == 0 ? 8'h00 : m == 1 ? 8'h80 : 8'hA0);
      b = xs();
      txSerial <= b[0];
      talk <= 1'b1;
      talkBit <= b[1];
      @(posedge clk);
      #1;
      chk("rx_route", rxSerial, m == 0 ? b[1] : b[0]);
    end
    talk <= 1'b0;
    txSerial <= 1'b1;
    wr(IDX_LINE_FMT, 8'h40);
    waitMode <= 1'b1;
    repeat (4) @(posedge clk);
    chk("wait_stop", {sciActive, txdOe, baudRunning}, 3'h0);
    wr(IDX_LINE_FMT, 8'h00);
    repeat (4) @(posedge clk);
    chk("wait_run", {sciActive, baudRunning}, 2'h3);
    waitMode <= 1'b0;
    $display("test routing and wait done");
    for (int i = 0; i < 16; i++) begin
      b = xs();
      wr(IDX_LINE_FMT, {3'h0, b[4:0]});
      txChar <= b[16:8];
      rxChar <= b[25:17];
      rxCharValid <= 1'b1;
      @(posedge clk);
      rxCharValid <= 1'b0;
      @(posedge clk);
      #1;
      chk("format", {nineBitChar, wakeAddrMark, idleAfterStop, parityEnable, parityOdd}, b[4:0]);
      if (b[1]) chk("tx_parity", txParityBit, tpar(b));
    end
    wr(IDX_LINE_FMT, 8'h10);
    wr(IDX_STAT_TWO, 8'h80);
    rdc("alt_idx0", IDX_DIV_HIGH, 8'h00);
    wr(IDX_LINE_FMT, 8'hEF);
    rdc("alt_ctl2", IDX_LINE_FMT, 8'h07);
    chk("fmt_hidden", nineBitChar, 1);
    wr(IDX_STAT_TWO, 8'h00);
    rdc("fmt_back", IDX_LINE_FMT, 8'h10);
    $display("test format and alt map done");
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    chk("rerun_stopped", baudRunning, 0);
    rdc("rerun_div_low", IDX_DIV_LOW, RST_DIV_LOW);
    $display("test mid reset done");
    print_verdict();
  end
endmodule
